// ---- include/psd_pkg.sv ----
// =====================================================================
// Port 0 soft strap defaults: shared constants and types
package psd_pkg;

    // Register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // Register offsets (word index on the plain port)
    localparam logic [ADDR_W-1:0] OFS_FLOW_CTRL  = 4'h0; // Port 0 flow control bits
    localparam logic [ADDR_W-1:0] OFS_PARTNER    = 4'h1; // virtual_phy_partner_ability_reg
    localparam logic [ADDR_W-1:0] OFS_ADVERTISE  = 4'h2; // virtual_phy_advertisement_reg
    localparam logic [ADDR_W-1:0] OFS_SPECIAL    = 4'h3; // virtual_phy_special_ctrl_stat_reg
    localparam logic [ADDR_W-1:0] OFS_STRAP_STAT = 4'h4; // Final straps and mode, read only

    // Flow control register fields
    localparam int FC_BP_BIT    = 0;
    localparam int FC_TX_BIT    = 1;
    localparam int FC_RX_BIT    = 2;
    localparam int FC_FIXED_BIT = 3;

    // Partner ability register fields
    localparam int LP_10HD_BIT  = 5;
    localparam int LP_10FD_BIT  = 6;
    localparam int LP_100HD_BIT = 7;
    localparam int LP_100FD_BIT = 8;
    localparam int LP_PAUSE_BIT = 10;
    localparam int LP_ASYM_BIT  = 11;

    // Advertisement register fields
    localparam int ADV_SYM_BIT  = 10;
    localparam int ADV_ASYM_BIT = 11;

    // Special control and status field
    localparam int SPC_HB_BIT   = 0;

    // Strap status register fields
    localparam int ST_POL_BIT   = 0;
    localparam int ST_BP_BIT    = 1;
    localparam int ST_FDFC_BIT  = 2;
    localparam int ST_FIXED_BIT = 3;
    localparam int ST_HB_BIT    = 4;
    localparam int ST_MODE_LSB  = 5;
    localparam int ST_FDX_BIT   = 7;

    // Strap defaults when nothing overrides them
    localparam logic DEF_BP    = 1'b1;
    localparam logic DEF_FDFC  = 1'b1;
    localparam logic DEF_FIXED = 1'b0;
    localparam logic DEF_HB    = 1'b0;
    localparam logic DEF_POL   = 1'b1;

    // Port 0 mode codes as latched from the mode pins
    localparam logic [1:0] MODE_MII_MAC  = 2'h0;
    localparam logic [1:0] MODE_MII_PHY  = 2'h1;
    localparam logic [1:0] MODE_RMII_PHY = 2'h2;

    // Soft strap set
    typedef struct packed {
        logic duplex_pol;
        logic bp;
        logic fdfc;
        logic fixed;
        logic hb;
    } psd_strap_type;

    // Port 0 flow control bits presented to the switch fabric
    typedef struct packed {
        logic backpressure_enable;
        logic tx_pause_enable;
        logic rx_pause_enable;
        logic fixed_pause_select;
    } psd_fc_type;

    // Plain register port request
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } psd_bus_req_type;

endpackage

// ---- src/psd_strap_defaults.sv ----
`timescale 1ns/1ps
// Behaviour
// - In MII MAC mode the polarity strap decides which duplex input level means full.
// - Polarity strap sets reset defaults of the four partner duplex ability bits.
// - Backpressure strap gives backpressure enable default; strap itself defaults to one.
// - Full-duplex pause strap gives tx and rx pause enable defaults; defaults one.
// - Full-duplex pause strap also sets partner asymmetric pause and pause defaults.
// - Fixed pause strap gives fixed pause select default; strap itself defaults zero.
// - Fixed pause strap also sets advertised asymmetric and symmetric pause defaults.
// - In MAC mode the fixed pause strap is ignored.
// - In MII PHY mode heartbeat strap gives heartbeat suppress default; defaults zero.
// - In RMII PHY and MII MAC modes the heartbeat strap is disregarded.
// - Soft straps can be replaced by values from the EEPROM loader.
module psd_strap_defaults
    import psd_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  srst,
    input  wire logic                  duplex_pol_pin,
    input  wire logic [1:0]            port0_mode_pins,
    input  wire logic                  port0_duplex_indication_input,
    input  wire logic                  eeprom_strap_valid,
    input  wire psd_strap_type         eeprom_strap,
    input  wire psd_bus_req_type       bus_req,
    output logic      [DATA_W-1:0]     bus_rdata,
    output psd_fc_type                 port0_fc,
    output logic                       port0_full_duplex,
    output logic                       heartbeat_suppress
);

    // =================================================================
    // Pin synchronisers

    logic [1:0]    pol_meta_q;
    logic [1:0]    mode_meta_q [2];
    logic [1:0]    dpx_meta_q;

    // Two stages per pin bit, second stage is the only reader of the first
    always_ff @(posedge ref_clk) begin
        pol_meta_q <= {pol_meta_q[0], duplex_pol_pin};
        dpx_meta_q <= {dpx_meta_q[0], port0_duplex_indication_input};
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_mode_sync
            // Mode pin bit synchroniser
            always_ff @(posedge ref_clk) begin
                mode_meta_q[gi] <= {mode_meta_q[gi][0], port0_mode_pins[gi]};
            end
        end
    endgenerate

    // =================================================================
    // Strap latch

    psd_strap_type strap_q;
    logic [1:0]    mode_q;
    logic          apply_q;

    // Pin strap and defaults caught while reset is held, loader replaces later
    // Pin read only through its synchroniser: reset must last three edges
    // with the pin steady for the latched level to be the pin level
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            strap_q.duplex_pol <= pol_meta_q[1];
            strap_q.bp         <= DEF_BP;
            strap_q.fdfc       <= DEF_FDFC;
            strap_q.fixed      <= DEF_FIXED;
            strap_q.hb         <= DEF_HB;
        end else if (eeprom_strap_valid) begin
            strap_q <= eeprom_strap;
        end
    end

    // Mode is a hard strap: latched at reset only, never from the loader
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_q <= {mode_meta_q[1][1], mode_meta_q[0][1]};
        end
    end

    // Defaults are pushed one cycle after reset or after a loader update
    // A loader pulse thus acts like a register reset for every default
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            apply_q <= 1'b1;
        end else begin
            apply_q <= eeprom_strap_valid;
        end
    end

    // =================================================================
    // Default values derived from the straps

    logic mac_mode;
    logic phy_mode;
    logic fixed_eff;
    logic hb_eff;

    // Mode decode; the reserved code counts as neither MAC nor PHY
    assign mac_mode  = (mode_q == MODE_MII_MAC);
    assign phy_mode  = (mode_q == MODE_MII_PHY);

    // Straps gated by mode: fixed pause means nothing without the virtual PHY
    assign fixed_eff = strap_q.fixed & ~mac_mode;
    assign hb_eff    = strap_q.hb & phy_mode;

    // Reload in reset and in the apply cycle; a software write landing
    // in that cycle is lost, since the default load has priority
    logic load;
    assign load = srst | apply_q;

    // =================================================================
    // Register bits

    psd_fc_type        fc_q;
    logic [DATA_W-1:0] lp_q;
    logic [DATA_W-1:0] adv_q;
    logic [DATA_W-1:0] spc_q;

    logic wr_fc;
    logic wr_lp;
    logic wr_adv;
    logic wr_spc;

    // Write decode; the strap status word has no write path
    assign wr_fc  = bus_req.wr & (bus_req.addr == OFS_FLOW_CTRL);
    assign wr_lp  = bus_req.wr & (bus_req.addr == OFS_PARTNER);
    assign wr_adv = bus_req.wr & (bus_req.addr == OFS_ADVERTISE);
    assign wr_spc = bus_req.wr & (bus_req.addr == OFS_SPECIAL);

    // Flow control bits: strap defaults, then software owns them
    always_ff @(posedge ref_clk) begin
        if (load) begin
            fc_q.backpressure_enable <= strap_q.bp;
            fc_q.tx_pause_enable     <= strap_q.fdfc;
            fc_q.rx_pause_enable     <= strap_q.fdfc;
            fc_q.fixed_pause_select  <= fixed_eff;
        end else if (wr_fc) begin
            // Host programs pause in every mode, MAC mode included
            fc_q.backpressure_enable <= bus_req.wdata[FC_BP_BIT];
            fc_q.tx_pause_enable     <= bus_req.wdata[FC_TX_BIT];
            fc_q.rx_pause_enable     <= bus_req.wdata[FC_RX_BIT];
            fc_q.fixed_pause_select  <= bus_req.wdata[FC_FIXED_BIT];
        end
    end

    // Partner ability register
    always_ff @(posedge ref_clk) begin
        if (load) begin
            lp_q               <= '0;
            lp_q[LP_100FD_BIT] <= strap_q.duplex_pol;
            lp_q[LP_100HD_BIT] <= ~strap_q.duplex_pol;
            lp_q[LP_10FD_BIT]  <= strap_q.duplex_pol;
            lp_q[LP_10HD_BIT]  <= ~strap_q.duplex_pol;
            lp_q[LP_PAUSE_BIT] <= strap_q.fdfc;
            lp_q[LP_ASYM_BIT]  <= strap_q.fdfc;
        end else if (wr_lp) begin
            lp_q <= bus_req.wdata;
        end
    end

    // Advertisement register
    always_ff @(posedge ref_clk) begin
        if (load) begin
            adv_q               <= '0;
            adv_q[ADV_SYM_BIT]  <= fixed_eff;
            adv_q[ADV_ASYM_BIT] <= fixed_eff;
        end else if (wr_adv) begin
            adv_q <= bus_req.wdata;
        end
    end

    // Special control and status register
    always_ff @(posedge ref_clk) begin
        if (load) begin
            spc_q             <= '0;
            spc_q[SPC_HB_BIT] <= hb_eff;
        end else if (wr_spc) begin
            spc_q <= bus_req.wdata;
        end
    end

    // =================================================================
    // Duplex indication decode

    // Polarity strap gives the full duplex level in MII MAC mode only
    // Elsewhere the partner full duplex ability bits decide
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            port0_full_duplex <= 1'b0;
        end else if (mac_mode) begin
            port0_full_duplex <= ~(dpx_meta_q[1] ^ strap_q.duplex_pol);
        end else begin
            port0_full_duplex <= lp_q[LP_100FD_BIT] | lp_q[LP_10FD_BIT];
        end
    end

    // =================================================================
    // Outputs to the fabric

    // Registered flow control copy, one cycle behind the register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            port0_fc <= '0;
        end else begin
            port0_fc <= fc_q;
        end
    end

    // Registered heartbeat suppress copy from the special register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            heartbeat_suppress <= 1'b0;
        end else begin
            heartbeat_suppress <= spc_q[SPC_HB_BIT];
        end
    end

    // =================================================================
    // Read path

    logic [DATA_W-1:0] rd_mux;

    // Read data selection, unmapped offsets read zero
    // Reads have no side effects, so back to back strobes are harmless
    always_comb begin
        rd_mux = '0;
        case (bus_req.addr)
            OFS_FLOW_CTRL: begin
                rd_mux[FC_BP_BIT]    = fc_q.backpressure_enable;
                rd_mux[FC_TX_BIT]    = fc_q.tx_pause_enable;
                rd_mux[FC_RX_BIT]    = fc_q.rx_pause_enable;
                rd_mux[FC_FIXED_BIT] = fc_q.fixed_pause_select;
            end
            OFS_PARTNER: begin
                rd_mux = lp_q;
            end
            OFS_ADVERTISE: begin
                rd_mux = adv_q;
            end
            OFS_SPECIAL: begin
                rd_mux = spc_q;
            end
            OFS_STRAP_STAT: begin
                rd_mux[ST_POL_BIT]                = strap_q.duplex_pol;
                rd_mux[ST_BP_BIT]                 = strap_q.bp;
                rd_mux[ST_FDFC_BIT]               = strap_q.fdfc;
                rd_mux[ST_FIXED_BIT]              = strap_q.fixed;
                rd_mux[ST_HB_BIT]                 = strap_q.hb;
                rd_mux[ST_MODE_LSB+1:ST_MODE_LSB] = mode_q;
                rd_mux[ST_FDX_BIT]                = port0_full_duplex;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bus_rdata <= '0;
        end else if (bus_req.rd) begin
            bus_rdata <= rd_mux;
        end else begin
            bus_rdata <= '0;
        end
    end

    // =================================================================
    // Elaboration checks

    // Partner ability fields inside the data word
    if (LP_ASYM_BIT >= DATA_W || LP_PAUSE_BIT >= DATA_W) begin : g_bad_partner
        $error("partner ability field outside the data word");
    end

    // Advertisement fields inside the data word
    if (ADV_ASYM_BIT >= DATA_W || ADV_SYM_BIT >= DATA_W) begin : g_bad_adv
        $error("advertisement field outside the data word");
    end

    // Status fields inside the word, mode field clear of the duplex bit
    if (ST_FDX_BIT >= DATA_W || ST_MODE_LSB + 1 >= ST_FDX_BIT) begin : g_bad_status
        $error("strap status field placement invalid");
    end

    // Flow control and special fields inside the data word
    if (FC_FIXED_BIT >= DATA_W || SPC_HB_BIT >= DATA_W) begin : g_bad_ctrl
        $error("control field outside the data word");
    end

    // Mode code width must match the mode pins
    if ($bits(MODE_MII_MAC) != 2) begin : g_bad_mode
        $error("mode code width does not match the mode pins");
    end

endmodule

// ---- test/port0_soft_strap_defaults_test.sv ----
`timescale 1ns/1ps
// ====================================================================
// Self-checking bench with a behavioural register model
module port0_soft_strap_defaults_test
    import psd_pkg::*;
;
    logic              ref_clk, srst, dup_in, esv, pol_pin, fdx, hb_out;
    logic [1:0]        mode_pins;
    logic [DATA_W-1:0] rdata, d;
    psd_strap_type     es;
    psd_bus_req_type   req;
    psd_fc_type        fc;
    int                num_errors, samples_checked, mdl[4], pol, bp, fdfc, fix, hb, mode, w;

    psd_strap_src u_src (.ref_clk(ref_clk), .duplex_pol_pin(pol_pin),
        .port0_mode_pins(mode_pins), .eeprom_strap_valid(esv), .eeprom_strap(es));
    psd_strap_defaults i_dut (.ref_clk(ref_clk), .srst(srst), .duplex_pol_pin(pol_pin),
        .port0_mode_pins(mode_pins), .port0_duplex_indication_input(dup_in),
        .eeprom_strap_valid(esv), .eeprom_strap(es), .bus_req(req), .bus_rdata(rdata),
        .port0_fc(fc), .port0_full_duplex(fdx), .heartbeat_suppress(hb_out));

    // Clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        #2ms;
        num_errors++;
        test_done();
    end

    // Model: register defaults from the current straps
    task model_apply();
        int fe;
        fe = (mode == 0) ? 0 : fix;
        mdl[0] = (bp << FC_BP_BIT) | (fdfc << FC_TX_BIT) | (fdfc << FC_RX_BIT) | (fe << FC_FIXED_BIT);
        mdl[1] = (pol << LP_100FD_BIT) | ((1 - pol) << LP_100HD_BIT) | (pol << LP_10FD_BIT)
            | ((1 - pol) << LP_10HD_BIT) | (fdfc << LP_PAUSE_BIT) | (fdfc << LP_ASYM_BIT);
        mdl[2] = (fe << ADV_SYM_BIT) | (fe << ADV_ASYM_BIT);
        mdl[3] = (mode == 1) ? hb : 0;
    endtask
    function automatic int mask_of(int a);
        case (a)
            0: return 16'h000f;
            1: return 16'h0de0;
            2: return 16'h0c00;
            default: return 16'h0001;
        endcase
    endfunction

    // Comparisons
    task chk_reg(input logic [15:0] got, input int exp, input int m);
        samples_checked++;
        if ((got & m[15:0]) !== (exp[15:0] & m[15:0])) begin
            num_errors++;
            $display("BAD %0t reg %h exp %h", $time, got, exp[15:0]);
        end
    endtask
    task chk_pin(input logic got, input int exp);
        samples_checked++;
        if (got !== exp[0]) begin
            num_errors++;
            $display("BAD %0t pin %b exp %0d", $time, got, exp);
        end
    endtask

    // Register port cycles
    task bus_wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= v;
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask
    task bus_rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1 v = rdata;
    endtask

    // Reads every register and output against the model
    task check_all();
        int e;
        for (int a = 0; a < 4; a++) begin
            bus_rd(a[3:0], d);
            chk_reg(d, mdl[a], mask_of(a));
        end
        chk_reg({12'h000, fc.fixed_pause_select, fc.rx_pause_enable, fc.tx_pause_enable,
            fc.backpressure_enable}, mdl[0], 16'h000f);
        chk_pin(hb_out, mdl[3]);
        e = (mode == 0) ? (dup_in == pol[0]) : pol;
        chk_pin(fdx, e);
        bus_rd(OFS_STRAP_STAT, d);
        chk_reg(d, (e << ST_FDX_BIT) | (mode << ST_MODE_LSB) | (hb << ST_HB_BIT)
            | (fix << ST_FIXED_BIT) | (fdfc << ST_FDFC_BIT) | (bp << ST_BP_BIT)
            | (pol << ST_POL_BIT), 16'h00ff);
    endtask
    task do_reset(input int m, input int p);
        @(posedge ref_clk);
        u_src.set_pins(p, m);
        srst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        mode = m;
        pol = p;
        bp = DEF_BP;
        fdfc = DEF_FDFC;
        fix = DEF_FIXED;
        hb = DEF_HB;
        model_apply();
    endtask
    task do_load();
        psd_strap_type s;
        s = psd_strap_type'(5'($urandom));
        u_src.load(s);
        repeat (3) @(posedge ref_clk);
        {pol, bp, fdfc, fix, hb} = {31'd0, s.duplex_pol, 31'd0, s.bp, 31'd0, s.fdfc,
            31'd0, s.fixed, 31'd0, s.hb};
        model_apply();
    endtask

    task test_done();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence over all four mode codes
    initial begin
        srst = 1'b1;
        dup_in = 1'b0;
        req = '0;
        num_errors = 0;
        samples_checked = 0;
        void'($urandom(80));
        for (int m = 0; m < 4; m++) begin
            do_reset(m, $urandom % 2);
            dup_in <= 1'($urandom % 2);
            check_all();
            repeat (2) begin
                do_load();
                check_all();
            end
            w = $urandom;
            bus_wr(OFS_FLOW_CTRL, w[15:0]);
            mdl[0] = w & 16'h000f;
            bus_wr(OFS_ADVERTISE, ~w[31:16]);
            mdl[2] = {16'h0000, ~w[31:16]};
            bus_wr(OFS_SPECIAL, w[31:16]);
            mdl[3] = {16'h0000, w[31:16]};
            bus_wr(OFS_STRAP_STAT, 16'hffff);
            dup_in <= ~dup_in;
            repeat (5) @(posedge ref_clk);
            check_all();
            bus_rd(4'hf, d);
            chk_reg(d, 0, 16'hffff);
        end
        test_done();
    end
endmodule

// ---- test/psd_chk.sv ----
`timescale 1ns/1ps
// ====================================================================
// Port checker for the strap default block
module psd_chk
    import psd_pkg::*;
(
    input wire logic            ref_clk,
    input wire logic            srst,
    input wire logic            duplex_pol_pin,
    input wire logic [1:0]      port0_mode_pins,
    input wire logic            port0_duplex_indication_input,
    input wire logic            eeprom_strap_valid,
    input wire psd_strap_type   eeprom_strap,
    input wire psd_bus_req_type bus_req,
    input wire logic [DATA_W-1:0] bus_rdata,
    input wire psd_fc_type      port0_fc,
    input wire logic            port0_full_duplex,
    input wire logic            heartbeat_suppress
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    // Duplex pin step in MAC mode with quiet cycles around it
    sequence s_dup_step;
        (!eeprom_strap_valid && $stable(port0_duplex_indication_input)
            && port0_mode_pins == MODE_MII_MAC)[*5]
        ##1 ($changed(port0_duplex_indication_input) && !eeprom_strap_valid)
        ##1 (!eeprom_strap_valid && $stable(port0_duplex_indication_input))[*3];
    endsequence
    // Loader pulse followed by three undisturbed cycles
    sequence s_load;
        (eeprom_strap_valid && !bus_req.wr)
        ##1 (!eeprom_strap_valid && !bus_req.wr)[*3];
    endsequence
    // Flow control write outside the apply cycles
    sequence s_fc_write;
        (bus_req.wr && bus_req.addr == OFS_FLOW_CTRL && !$past(srst)
            && !$past(eeprom_strap_valid) && !eeprom_strap_valid) ##1 !bus_req.wr;
    endsequence

    property p_rst_zero;
        @(posedge ref_clk) disable iff (1'b0) srst |=> port0_fc == '0
            && !heartbeat_suppress && !port0_full_duplex && bus_rdata == '0;
    endproperty
    property p_bp_default;
        $fell(srst) |=> port0_fc.backpressure_enable == DEF_BP;
    endproperty
    property p_pause_default;
        $fell(srst) |=> port0_fc.tx_pause_enable == DEF_FDFC
            && port0_fc.rx_pause_enable == DEF_FDFC && !port0_fc.fixed_pause_select;
    endproperty
    property p_hb_default;
        $fell(srst) |=> heartbeat_suppress == DEF_HB;
    endproperty
    property p_write_sticks;
        s_fc_write |=> port0_fc.backpressure_enable == $past(bus_req.wdata[FC_BP_BIT], 2)
            && port0_fc.tx_pause_enable == $past(bus_req.wdata[FC_TX_BIT], 2)
            && port0_fc.fixed_pause_select == $past(bus_req.wdata[FC_FIXED_BIT], 2);
    endproperty
    property p_fdx_follow;
        s_dup_step |-> port0_full_duplex != $past(port0_full_duplex, 4);
    endproperty
    property p_load_fc;
        s_load |-> port0_fc.backpressure_enable == $past(eeprom_strap.bp, 3)
            && port0_fc.tx_pause_enable == $past(eeprom_strap.fdfc, 3)
            && port0_fc.rx_pause_enable == $past(eeprom_strap.fdfc, 3);
    endproperty
    property p_load_fixed;
        s_load |-> port0_fc.fixed_pause_select
            == ($past(eeprom_strap.fixed, 3) && port0_mode_pins != MODE_MII_MAC);
    endproperty
    property p_load_hb;
        s_load |-> heartbeat_suppress
            == ($past(eeprom_strap.hb, 3) && port0_mode_pins == MODE_MII_PHY);
    endproperty
    property p_rdata_idle;
        !$past(bus_req.rd) |-> bus_rdata == '0;
    endproperty

    a_rst_zero: assert property (p_rst_zero) else $error("outputs not zero in reset");
    a_bp_default: assert property (p_bp_default) else $error("bad backpressure default");
    a_pause_default: assert property (p_pause_default) else $error("bad pause default");
    a_hb_default: assert property (p_hb_default) else $error("bad heartbeat default");
    a_write_sticks: assert property (p_write_sticks) else $error("write lost");
    a_fdx_follow: assert property (p_fdx_follow) else $error("duplex not followed");
    a_load_fc: assert property (p_load_fc) else $error("loader flow ctrl wrong");
    a_load_fixed: assert property (p_load_fixed) else $error("fixed pause wrong");
    a_load_hb: assert property (p_load_hb) else $error("heartbeat wrong");
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
endmodule

bind psd_strap_defaults psd_chk i_chk (.ref_clk(ref_clk), .srst(srst),
    .duplex_pol_pin(duplex_pol_pin), .port0_mode_pins(port0_mode_pins),
    .port0_duplex_indication_input(port0_duplex_indication_input),
    .eeprom_strap_valid(eeprom_strap_valid), .eeprom_strap(eeprom_strap),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .port0_fc(port0_fc),
    .port0_full_duplex(port0_full_duplex), .heartbeat_suppress(heartbeat_suppress));

// ---- test/psd_strap_src.sv ----
`timescale 1ns/1ps
// ====================================================================
// Strap pins and EEPROM loader at the far side of the block
module psd_strap_src
    import psd_pkg::*;
(
    input  wire logic    ref_clk,
    output logic         duplex_pol_pin,
    output logic [1:0]   port0_mode_pins,
    output logic         eeprom_strap_valid,
    output psd_strap_type eeprom_strap
);
    // Idle pins at time zero
    initial begin
        duplex_pol_pin = 1'b0;
        port0_mode_pins = 2'h0;
        eeprom_strap_valid = 1'b0;
        eeprom_strap = '0;
    end

    // Pin levels, held stable across the reset that latches them
    task set_pins(input int p, input int m);
        duplex_pol_pin <= p[0];
        port0_mode_pins <= m[1:0];
    endtask

    // One-cycle replacement pulse; data lines go stale afterwards
    task load(input psd_strap_type s);
        @(posedge ref_clk);
        eeprom_strap_valid <= 1'b1;
        eeprom_strap <= s;
        @(posedge ref_clk);
        eeprom_strap_valid <= 1'b0;
        eeprom_strap <= ~s; // Stale value, not the last one
    endtask
endmodule
